/* File: design/lcg_power_ctrl.sv */
// Functional notes
// - High bit 11 stops the flash clock.
// - High bits 9,8,7 stop PWM, timer, converter.
// - High bits 4,3,1,0 stop timers, ports.
// - Low bit 17 interrupt controller; 16-13 DMA timers.
// - Low bits 10,9,7-5,4 stop serial, DMA clocks.
// - Low bit 1 stops the global off-platform clock only.
// - Low register resets 0x8; bit 3 stays set.
// - Bus controller and system control never gated.
// - Gating bits change directly or through helpers.
// - Wake bit 7 enables stop mode.
// - Wake bits 6-4 hold exit priority level.
// - Stop instruction with enable enters stop mode.
// - Low-power entry disables core clocks.
// - Wake check is combinational, no gated clock.
// - Stop left only on fixed interrupts.
// - Qualifying interrupt raises exit, clocks return.
// - Level code 000 any, 11x only seven.
// - Set helper sets bit; 64-127 sets all.
// - Clear helper clears bit; clear wins.
// - Mode bits 7-6 select stop/wait/doze/run.
`timescale 1ns/1ns
module lcg_power_ctrl (
	// Clock and reset
	input  wire logic                      clock,
	input  wire logic                      reset_n,
	// APB slave
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [lcg_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]               pwdata,
	input  wire logic [3:0]                pstrb,
	output logic      [31:0]               prdata,
	output logic                           pready,
	output logic                           pslverr,
	// Processor core
	input  wire logic [3:0]                processor_status_code,
	output logic                           stop_entry,
	output logic                           exit_request,
	output logic                           core_clock_run,
	output logic                           core_clock,
	// Interrupt controller
	input  wire lcg_pkg::lcg_irq_t         irq_request,
	output lcg_pkg::lcg_mode_t             lowpower_mode,
	// Peripheral module clocks
	output lcg_pkg::lcg_gate_t             module_clock_off,
	output logic [lcg_pkg::GATE_N-1:0]     module_clock
);
	import lcg_pkg::*;

	function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [IDX_W-1:0] idx);
		hit = (addr[1:0] == 2'h0) && (addr[ADDR_W-1:2] == idx);
	endfunction : hit

	function automatic logic [31:0] lane_mask(input logic [3:0] strb);
		lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
	endfunction : lane_mask

	// Helper value selects one of 64 gating bits, or all of them
	function automatic logic [63:0] helper_vec(input logic [6:0] value);
		helper_vec = value[HELPER_ALL_BIT] ? {64{1'b1}} : (64'h1 << value[5:0]);
	endfunction : helper_vec

	function automatic logic [2:0] wake_min(input logic [2:0] code);
		wake_min = (code >= 3'h6) ? TOP_LEVEL : code + 3'h1;
	endfunction : wake_min

	function automatic lcg_gate_t gate_map(input logic [31:0] hi, input logic [31:0] lo);
		gate_map.flash_clock_off              = hi[FLASH_BIT];
		gate_map.pulse_width_clock_off        = hi[PWM_BIT];
		gate_map.general_timer_clock_off      = hi[GPT_BIT];
		gate_map.converter_clock_off          = hi[ADC_BIT];
		gate_map.periodic_timer1_clock_off    = hi[PIT1_BIT];
		gate_map.periodic_timer0_clock_off    = hi[PIT0_BIT];
		gate_map.edge_port_clock_off          = hi[EPORT_BIT];
		gate_map.ports_clock_off              = hi[PORTS_BIT];
		gate_map.irq_controller_clock_off     = lo[INTC_BIT];
		gate_map.dma_timer_clock_off          = lo[TMR3_BIT:TMR0_BIT];
		gate_map.queued_serial_clock_off      = lo[QSPI_BIT];
		gate_map.two_wire_clock_off           = lo[I2C_BIT];
		gate_map.serial_clock_off             = lo[UART2_BIT:UART0_BIT];
		gate_map.transfer_engine_clock_off    = lo[DMA_BIT];
		gate_map.global_offplatform_clock_off = lo[GLOBAL_BIT];
	endfunction : gate_map

	// Software registers
	logic [31:0]   gate_high;
	logic [31:0]   gate_low;
	logic [7:0]    wake_ctrl;
	logic [7:0]    mode_ctrl;
	lcg_lp_state_t state;
	lcg_mode_t     mode_entered;

	// Bus decode
	wire logic        setup     = psel & ~penable;
	wire logic        wr        = psel & penable & pready & pwrite;
	wire logic        sel_high  = hit(paddr, IDX_GATE_HIGH);
	wire logic        sel_low   = hit(paddr, IDX_GATE_LOW);
	wire logic        sel_wake  = hit(paddr, IDX_WAKE_CTRL);
	wire logic        sel_mode  = hit(paddr, IDX_MODE_CTRL);
	wire logic        sel_set   = hit(paddr, IDX_SET_HELPER);
	wire logic        sel_clr   = hit(paddr, IDX_CLR_HELPER);
	wire logic        sel_stat  = hit(paddr, IDX_LP_STATUS);
	wire logic        mapped    = sel_high | sel_low | sel_wake | sel_mode | sel_set | sel_clr | sel_stat;
	wire logic [31:0] wmask     = lane_mask(pstrb);

	// Gating register updates
	wire logic [63:0] set_vec   = (wr & sel_set & pstrb[0]) ? helper_vec(pwdata[6:0]) : 64'h0;
	wire logic [63:0] clr_vec   = (wr & sel_clr & pstrb[0]) ? helper_vec(pwdata[6:0]) : 64'h0;
	wire logic [31:0] wr_high   = (wr & sel_high) ? ((gate_high & ~wmask) | (pwdata & wmask)) : gate_high;
	wire logic [31:0] wr_low    = (wr & sel_low) ? ((gate_low & ~wmask) | (pwdata & wmask)) : gate_low;
	// Clear is applied after set so it takes priority
	wire logic [31:0] next_gate_high = ((wr_high | set_vec[63:32]) & ~clr_vec[63:32])
	                                   & GATE_HIGH_MASK;
	wire logic [31:0] next_gate_low  = (((wr_low | set_vec[31:0]) & ~clr_vec[31:0])
	                                   & GATE_LOW_MASK) | GATE_LOW_FIXED;
	wire logic [7:0]  next_wake_ctrl = (wr & sel_wake & pstrb[0]) ? (pwdata[7:0] & WAKE_MASK) : wake_ctrl;
	wire logic [7:0]  next_mode_ctrl = (wr & sel_mode & pstrb[0]) ? (pwdata[7:0] & MODE_MASK) : mode_ctrl;

	// Low-power sequencing
	wire logic        stopped      = (processor_status_code == PST_STOPPED);
	wire lcg_mode_t   mode_sel     = lcg_mode_t'(mode_ctrl[MODE_SEL_LSB+:2]);
	wire logic        stop_allowed = wake_ctrl[STOP_EN_BIT];
	wire logic        enter_ok     = stopped & (mode_sel != MODE_RUN)
	                                 & ((mode_sel != MODE_STOP) | stop_allowed);
	wire logic [2:0]  min_level    = wake_min(wake_ctrl[WAKE_LVL_LSB+:3]);
	// Purely combinational compare of the live request, no gated clock involved
	wire logic        wake_hit     = (irq_request.level != 3'h0) & (irq_request.level >= min_level)
	                                 & ((mode_entered != MODE_STOP) | irq_request.fixed);

	lcg_lp_state_t next_state;
	always_comb begin
		next_state = state;
		unique case (state)
			LP_RUN:  if (enter_ok) next_state = LP_LOW;
			LP_LOW:  if (wake_hit) next_state = LP_EXIT;
			LP_EXIT: if (!stopped) next_state = LP_RUN;
			default: next_state = LP_RUN;
		endcase
	end

	wire lcg_mode_t   next_mode_entered = (state == LP_RUN && enter_ok) ? mode_sel : mode_entered;
	wire logic        next_low          = (next_state == LP_LOW);
	wire logic        next_stop_low     = next_low & (next_mode_entered == MODE_STOP);
	// Stop also halts every peripheral clock; the bus controller and system control are not in the map
	wire lcg_gate_t   next_clock_off    = next_stop_low ? lcg_gate_t'({GATE_N{1'b1}})
	                                      : gate_map(next_gate_high, next_gate_low);

	wire lcg_status_t status_now = '{state: state, mode: mode_entered, spare: 1'b0,
	                                 exit_request: exit_request, stop_entry: stop_entry,
	                                 core_clock_run: core_clock_run};
	wire logic [31:0] read_value = sel_high ? gate_high
	                             : sel_low  ? gate_low
	                             : sel_wake ? {24'h000000, wake_ctrl}
	                             : sel_mode ? {24'h000000, mode_ctrl}
	                             : sel_stat ? {24'h000000, status_now}
	                             : 32'h00000000;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			gate_high <= GATE_HIGH_RESET;
			gate_low  <= GATE_LOW_RESET;
			wake_ctrl <= WAKE_RESET;
			mode_ctrl <= MODE_RESET;
		end else begin
			gate_high <= next_gate_high;
			gate_low  <= next_gate_low;
			wake_ctrl <= next_wake_ctrl;
			mode_ctrl <= next_mode_ctrl;
		end
	end

	// One wait-free access phase: answer is prepared during setup
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			prdata  <= 32'h00000000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			prdata  <= setup ? read_value : 32'h00000000;
			pready  <= setup;
			pslverr <= setup & ~mapped;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state            <= LP_RUN;
			mode_entered     <= MODE_RUN;
			stop_entry       <= 1'b0;
			exit_request     <= 1'b0;
			core_clock_run   <= 1'b1;
			lowpower_mode    <= MODE_RUN;
			module_clock_off <= lcg_gate_t'({GATE_N{1'b0}});
		end else begin
			state            <= next_state;
			mode_entered     <= next_mode_entered;
			stop_entry       <= next_stop_low;
			exit_request     <= (next_state == LP_EXIT);
			core_clock_run   <= ~next_low;
			lowpower_mode    <= next_low ? next_mode_entered : MODE_RUN;
			module_clock_off <= next_clock_off;
		end
	end

	// Latch-based clock gates; enable only moves while the clock is low
	logic [GATE_N:0] gate_run;
	logic [GATE_N:0] gate_latch;
	logic [GATE_N:0] gated;
	assign gate_run = {core_clock_run, ~module_clock_off};

	genvar g;
	generate
		for (g = 0; g <= GATE_N; g++) begin : g_clock_gate
			always_latch begin
				if (!clock) gate_latch[g] <= gate_run[g];
			end
			assign gated[g] = clock & gate_latch[g];
		end
	endgenerate

	assign module_clock = gated[GATE_N-1:0];
	assign core_clock   = gated[GATE_N];

endmodule : lcg_power_ctrl

/* File: design/lcg_pkg.sv */
package lcg_pkg;

	// Bus geometry; every register index is scaled by four into a byte address
	localparam int          ADDR_W          = 24;
	localparam int          IDX_W           = 22;

	// Register indices
	localparam logic [21:0] IDX_GATE_HIGH   = 22'h00000C;
	localparam logic [21:0] IDX_WAKE_CTRL   = 22'h000012;
	localparam logic [21:0] IDX_GATE_LOW    = 22'h000018;
	localparam logic [21:0] IDX_SET_HELPER  = 22'h000021;
	localparam logic [21:0] IDX_CLR_HELPER  = 22'h000022;
	localparam logic [21:0] IDX_LP_STATUS   = 22'h000030;
	localparam logic [21:0] IDX_MODE_CTRL   = 22'h110007;

	// Reset values
	localparam logic [31:0] GATE_HIGH_RESET = 32'h00000000;
	localparam logic [31:0] GATE_LOW_RESET  = 32'h00000008;
	localparam logic [7:0]  WAKE_RESET      = 8'h00;
	localparam logic [7:0]  MODE_RESET      = 8'h02;

	// Writable bits and fixed ones
	localparam logic [31:0] GATE_HIGH_MASK  = 32'h00000B9B;
	localparam logic [31:0] GATE_LOW_MASK   = 32'h0003E6F2;
	localparam logic [31:0] GATE_LOW_FIXED  = 32'h00000008;
	localparam logic [7:0]  WAKE_MASK       = 8'hF0;
	localparam logic [7:0]  MODE_MASK       = 8'hC2;

	// Field positions
	localparam int          STOP_EN_BIT     = 7;
	localparam int          WAKE_LVL_LSB    = 4;
	localparam int          MODE_SEL_LSB    = 6;
	localparam int          HELPER_ALL_BIT  = 6;

	// High gating register bits
	localparam int          FLASH_BIT       = 11;
	localparam int          PWM_BIT         = 9;
	localparam int          GPT_BIT         = 8;
	localparam int          ADC_BIT         = 7;
	localparam int          PIT1_BIT        = 4;
	localparam int          PIT0_BIT        = 3;
	localparam int          EPORT_BIT       = 1;
	localparam int          PORTS_BIT       = 0;
	// Low gating register bits
	localparam int          INTC_BIT        = 17;
	localparam int          TMR3_BIT        = 16;
	localparam int          TMR0_BIT        = 13;
	localparam int          QSPI_BIT        = 10;
	localparam int          I2C_BIT         = 9;
	localparam int          UART2_BIT       = 7;
	localparam int          UART0_BIT       = 5;
	localparam int          DMA_BIT         = 4;
	localparam int          GLOBAL_BIT      = 1;

	// Processor status code shown by a halted core; value is arbitrary
	localparam logic [3:0]  PST_STOPPED     = 4'hE;
	localparam logic [2:0]  TOP_LEVEL       = 3'h7;
	localparam int          GATE_N          = 20;

	typedef enum logic [1:0] {
		LP_RUN  = 2'b00,
		LP_LOW  = 2'b01,
		LP_EXIT = 2'b11
	} lcg_lp_state_t;

	typedef enum logic [1:0] {
		MODE_RUN  = 2'b00,
		MODE_DOZE = 2'b01,
		MODE_WAIT = 2'b10,
		MODE_STOP = 2'b11
	} lcg_mode_t;

	typedef struct packed {
		logic       flash_clock_off;
		logic       pulse_width_clock_off;
		logic       general_timer_clock_off;
		logic       converter_clock_off;
		logic       periodic_timer1_clock_off;
		logic       periodic_timer0_clock_off;
		logic       edge_port_clock_off;
		logic       ports_clock_off;
		logic       irq_controller_clock_off;
		logic [3:0] dma_timer_clock_off;
		logic       queued_serial_clock_off;
		logic       two_wire_clock_off;
		logic [2:0] serial_clock_off;
		logic       transfer_engine_clock_off;
		logic       global_offplatform_clock_off;
	} lcg_gate_t;

	typedef struct packed {
		logic [2:0] level;
		logic       fixed;
	} lcg_irq_t;

	typedef struct packed {
		lcg_lp_state_t state;
		lcg_mode_t     mode;
		logic          spare;
		logic          exit_request;
		logic          stop_entry;
		logic          core_clock_run;
	} lcg_status_t;

endpackage : lcg_pkg

/* File: tb/lcg_assertions.sv */
`timescale 1ns/1ns
module lcg_assertions
	import lcg_pkg::*;
(
	// Clock and reset
	input wire logic				clock,
	input wire logic				reset_n,
	// Register bus
	input wire logic				psel,
	input wire logic				penable,
	input wire logic				pwrite,
	input wire logic [lcg_pkg::ADDR_W-1:0]	paddr,
	input wire logic [31:0]			prdata,
	input wire logic				pready,
	// Core and interrupts
	input wire logic [3:0]			processor_status_code,
	input wire logic				stop_entry,
	input wire logic				exit_request,
	input wire logic				core_clock_run,
	input wire lcg_pkg::lcg_irq_t	irq_request,
	input wire lcg_pkg::lcg_mode_t	lowpower_mode,
	// Module clocks
	input wire lcg_pkg::lcg_gate_t	module_clock_off
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);
	sequence s_read(a);
		psel && penable && pready && !pwrite && paddr == a;
	endsequence
	sequence s_low;
		lowpower_mode != MODE_RUN;
	endsequence
	chk_high_gate_view: assert property (s_read(24'h30) ##0 core_clock_run |->
		module_clock_off[19:12] == {prdata[11], prdata[9:7], prdata[4:3], prdata[1:0]}) else $error("high gates differ");
	chk_low_gate_view: assert property (s_read(24'h60) ##0 core_clock_run |-> prdata[3] &&
		module_clock_off[11:0] == {prdata[17:13], prdata[10:9], prdata[7:4], prdata[1]}) else $error("low gates differ");
	chk_helper_reads: assert property ((s_read(24'h84) or s_read(24'h88)) |-> prdata == 32'h0)
		else $error("helper read not zero");
	chk_stop_all_off: assert property (stop_entry |-> lowpower_mode == MODE_STOP && module_clock_off == '1
		&& !core_clock_run) else $error("stop clocks wrong");
	chk_core_held: assert property (s_low |-> !core_clock_run && !exit_request)
		else $error("core clock runs in low power");
	chk_stop_fixed_only: assert property (stop_entry && !irq_request.fixed |=> !exit_request)
		else $error("stop left on non-fixed request");
	chk_no_wake_idle: assert property (s_low ##0 irq_request.level == 3'h0 |=> !exit_request)
		else $error("wake without request");
	chk_top_wake: assert property (s_low ##0 irq_request.level == 3'h7 && (irq_request.fixed || !stop_entry)
		|=> exit_request && lowpower_mode == MODE_RUN) else $error("level seven did not wake");
	chk_exit_hold: assert property (exit_request && processor_status_code == PST_STOPPED |=> exit_request
		&& core_clock_run) else $error("exit request dropped early");
	chk_exit_gone: assert property (exit_request && processor_status_code != PST_STOPPED |=> !exit_request)
		else $error("exit request stuck");
endmodule : lcg_assertions
bind lcg_power_ctrl lcg_assertions u_chk (.clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .processor_status_code(processor_status_code),
	.stop_entry(stop_entry), .exit_request(exit_request), .core_clock_run(core_clock_run),
	.irq_request(irq_request), .lowpower_mode(lowpower_mode), .module_clock_off(module_clock_off));

/* File: tb/lcg_core_model.sv */
`timescale 1ns/1ns
module lcg_core_model
	import lcg_pkg::*;
(
	// Clock and reset
	input wire logic			clock,
	input wire logic			reset_n,
	// Bench commands
	input wire logic			stop_cmd,
	input wire logic [2:0]		irq_level,
	input wire logic			irq_fixed,
	// Block side
	input wire logic			core_clock_run,
	output logic [3:0]			processor_status_code,
	output lcg_pkg::lcg_irq_t	irq_request
);
	logic halted;
	// Pending request reaches the block without any clock
	assign irq_request = {irq_level, irq_fixed};
	assign processor_status_code = halted ? PST_STOPPED : 4'h0;
	// A clocked core with a pending request resumes execution
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			halted <= 1'b0;
		else if (core_clock_run && irq_level != 3'h0)
			halted <= 1'b0;
		else if (stop_cmd)
			halted <= 1'b1;
	end
endmodule : lcg_core_model

/* File: tb/lcg_power_ctrl_tb_top.sv */
`timescale 1ns/1ns
module lcg_power_ctrl_tb_top;
	import lcg_pkg::*;
	logic			clock, reset_n, psel, penable, pwrite, stop_cmd, irq_fixed, err;
	logic			pready, pslverr, stop_entry, exit_request, core_clock_run, core_clock;
	logic [23:0]	paddr;
	logic [31:0]	pwdata, prdata, rd;
	logic [3:0]		pstrb, status_code;
	logic [2:0]		irq_level;
	logic [19:0]	module_clock;
	lcg_irq_t		irq_request;
	lcg_mode_t		lowpower_mode;
	lcg_gate_t		module_clock_off;
	int				bad_count, check_count;
	always #20 clock = ~clock;
	lcg_power_ctrl dut (.clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.processor_status_code(status_code), .stop_entry(stop_entry), .exit_request(exit_request),
		.core_clock_run(core_clock_run), .core_clock(core_clock), .irq_request(irq_request),
		.lowpower_mode(lowpower_mode), .module_clock_off(module_clock_off), .module_clock(module_clock));
	lcg_core_model u_core (.clock(clock), .reset_n(reset_n), .stop_cmd(stop_cmd), .irq_level(irq_level),
		.irq_fixed(irq_fixed), .core_clock_run(core_clock_run), .processor_status_code(status_code),
		.irq_request(irq_request));
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	// Waits for pready with no cycle limit; only the watchdog ends a hung transfer
	task automatic apb(input logic wr, input logic [23:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// One idle cycle so the next call never re-drives psel in this time step
		@(posedge clock);
	endtask : apb
	task automatic rdchk(input logic [23:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check($sformatf("read %h", a), rd, exp);
	endtask : rdchk
	task automatic t_reset();
		rdchk(24'h30, 32'h0);
		rdchk(24'h48, 32'h0);
		rdchk(24'h60, 32'h8);
		rdchk(24'h44001C, 32'h2);
		rdchk(24'hC0, 32'h1);
		apb(1'b0, 24'h4, 32'h0);
		check("unmapped", 32'(err), 32'h1);
	endtask : t_reset
	task automatic t_gates();
		apb(1'b1, 24'h30, 32'hFFFFFFFF); // no peripheral is active while gated
		apb(1'b1, 24'h60, 32'hFFFFFFFF);
		rdchk(24'h30, 32'hB9B);
		rdchk(24'h60, 32'h3E6FA);
		#10 check("all off", 32'(module_clock_off), 32'hFFFFF);
		check("gated low", 32'(module_clock), 32'h0);
		@(posedge clock);
		apb(1'b1, 24'h30, 32'h0);
		apb(1'b1, 24'h60, 32'h0);
		rdchk(24'h60, 32'h8);
		#10 check("running", 32'(module_clock), 32'hFFFFF);
		check("core running", 32'(core_clock), 32'h1);
		@(posedge clock);
	endtask : t_gates
	task automatic t_help();
		apb(1'b1, 24'h84, 32'h2B);
		apb(1'b1, 24'h84, 32'h1);
		rdchk(24'h30, 32'h800);
		rdchk(24'h84, 32'h0);
		check("flash global", 32'(module_clock_off), 32'h80001);
		apb(1'b1, 24'h88, 32'h2B);
		rdchk(24'h60, 32'hA);
		rdchk(24'h30, 32'h0);
		apb(1'b1, 24'h84, 32'h40);
		rdchk(24'h30, 32'hB9B);
		apb(1'b1, 24'h88, 32'h7F);
		rdchk(24'h60, 32'h8);
	endtask : t_help
	task automatic t_lp(input lcg_mode_t m, input logic [7:0] wake, input logic [2:0] lo, input logic [2:0] hi);
		apb(1'b1, 24'h44001C, {24'h0, m, 6'h02});
		apb(1'b1, 24'h48, {24'h0, wake});
		stop_cmd <= 1'b1;
		@(posedge clock);
		stop_cmd <= 1'b0;
		repeat (4) @(posedge clock);
		if (m == MODE_RUN || (m == MODE_STOP && !wake[7])) begin
			check("refused", 32'(core_clock_run), 32'h1);
			irq_level <= 3'h1;
		end else begin
			check("mode", 32'(lowpower_mode), 32'(m));
			check("stop entry", 32'(stop_entry), 32'(m == MODE_STOP));
			irq_level <= lo;
			irq_fixed <= (m != MODE_STOP);
			repeat (3) @(posedge clock);
			#10 check("no wake", 32'(core_clock_run), 32'h0);
			check("core clock held", 32'(core_clock), 32'h0);
			check("module clocks", 32'(module_clock), (m == MODE_STOP) ? 32'h0 : 32'hFFFFF);
			@(posedge clock);
			// Wait and doze also wake on a programmable request; stop needs a fixed one
			irq_level <= hi;
			irq_fixed <= (m == MODE_STOP);
			do @(posedge clock); while (exit_request !== 1'b1);
			check("wake", 32'({core_clock_run, lowpower_mode}), 32'h4);
		end
		do @(posedge clock); while (exit_request !== 1'b0 || status_code === PST_STOPPED);
		irq_level <= 3'h0;
		irq_fixed <= 1'b0;
		@(posedge clock);
	endtask : t_lp
	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : finish_test
	initial begin
		#2000000;
		bad_count++;
		finish_test();
	end
	initial begin
		clock = 1'b0;
		reset_n = 1'b0;
		{psel, penable, pwrite, stop_cmd, irq_fixed} = '0;
		{paddr, pwdata, irq_level} = '0;
		pstrb = 4'hF;
		repeat (5) @(posedge clock);
		reset_n <= 1'b1;
		@(posedge clock);
		t_reset();
		t_gates();
		t_help();
		t_lp(MODE_DOZE, 8'h00, 3'h0, 3'h1);
		t_lp(MODE_WAIT, 8'h30, 3'h3, 3'h4);
		t_lp(MODE_WAIT, 8'h60, 3'h6, 3'h7);
		t_lp(MODE_RUN, 8'h80, 3'h0, 3'h1);
		t_lp(MODE_STOP, 8'h60, 3'h7, 3'h7);
		t_lp(MODE_STOP, 8'hF0, 3'h7, 3'h7);
		finish_test();
	end
endmodule : lcg_power_ctrl_tb_top
